// File: verilog/cdlc_top.sv
// Operation
// R1: Format bit clear streams, set uses blocks
// R2: Multi-block bit picks single or multiple blocks
// R3: Length is two to code bytes, max 2048
// R4: Direction set transmits, clear receives
// R5: Software preloads up to sixteen bytes first
// R6: Start bit set then cleared starts transfer
// R7: Write waits for good response before sending
// R8: Card busy on data line holds transmission
// R9: Write gap is three plus two per step
// R10: Stream write ends with end bit, flags frame
// R11: Block write flags frame after status token
// R12: Busy mirrored; each busy change sets flag
// R13: Receive end reports end bit and CRC
// R14: Controller reset bit returns machine to idle
// R15: Software times out waiting for read data
// R16: Software drains each full half by eight reads
// R17: Transmit flow control stops clock when empty
// R18: Receive flow control stops clock when full
// R19: Stopped bus freezes until data register access
// R20: Eight maskable interrupt flags
// R21: Unmasked set flag with global enable interrupts
// R22: Reading flag register clears all flags; code clears only the flags the read returned, keeping new events
// R23: Buffer is two halves with full/empty flags
// R24: Pointer reset bits abort buffer transfer
// R25: Halves fill and drain alternately
`timescale 1ns/100ps
`default_nettype none
module cdlc_top (
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [cdlc_pkg::AW-1:0] paddr, // APB byte address
	input wire logic [cdlc_pkg::DW-1:0] pwdata, // APB write data
	output logic [cdlc_pkg::DW-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic card_clock, // Card clock as seen on the pin
	input wire logic card_dat_in, // Card data line level
	output logic card_dat_out, // Data driven to the card
	output logic card_dat_oe_n, // Low while driving the data line
	output logic card_clock_run, // Low asks the clock source to stop
	input wire logic resp_done, // Response received, one-cycle pulse
	input wire logic resp_ok, // Response status good, valid with resp_done
	input wire logic cmd_done, // Command sent, one-cycle pulse
	input wire logic irq_global_en, // Global interrupt enable
	output logic irq_req // Interrupt request level
);
	import cdlc_pkg::*;

	typedef enum logic [12:0] {
		S_IDLE = 13'h0001,
		S_WRESP = 13'h0002,
		S_GAP = 13'h0004,
		S_TSTART = 13'h0008,
		S_TDATA = 13'h0010,
		S_TCRC = 13'h0020,
		S_TEND = 13'h0040,
		S_TTOK = 13'h0080,
		S_TBUSY = 13'h0100,
		S_RWAIT = 13'h0200,
		S_RDATA = 13'h0400,
		S_RCRC = 13'h0800,
		S_REND = 13'h1000
	} cdlc_state_e;

	typedef struct packed {
		cdlc_state_e st;
		logic fmt;
		logic multi;
		logic rprst;
		logic wprst;
		logic [3:0] blen;
		logic dir;
		logic startb;
		logic flow;
		logic [1:0] dly;
		logic data_ctrl_reset;
		logic [IW-1:0] mask;
		logic [IW-1:0] flags;
		logic [3:0] lvl;
		logic xdir;
		logic xblk;
		logic xmulti;
		logic [11:0] xlen;
		logic resp_seen;
		logic resp_good;
		logic stop_seen;
		logic fmt_ok;
		logic crc_ok;
		logic busy;
		logic clk_prev;
		logic [3:0] gap;
		logic [3:0] bits;
		logic [11:0] nbytes;
		logic [2:0] tok;
		logic [15:0] crc;
		logic [15:0] sh;
		logic dout;
		logic doe_n;
		logic run;
		logic irq;
		logic [DW-1:0] rdata;
		logic ready;
		logic err;
	} cdlc_regs_s;

	cdlc_regs_s s;
	cdlc_regs_s n;
	logic ck_s;
	logic dat_s;
	logic rise;
	logic fall;
	logic acc;
	logic done;
	logic start_ev;
	logic active;
	logic [IW-1:0] fset;
	logic [IW-1:0] rd_snap;
	logic [3:0] lvl;
	logic [7:0] rx_byte;
	logic push;
	logic pop;
	logic [7:0] push_data;
	logic [7:0] fifo_out;
	logic can_push;
	logic can_pop;
	logic [1:0] hfull;
	logic [1:0] hempty;

	// One CCITT step, shared by the sending and receiving paths
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction

	// Write gap in card clock periods
	function automatic logic [3:0] gap_target(input logic [1:0] d);
		gap_target = GAP_BASE + 4'(GAP_STEP * int'(d));
	endfunction

	// Pin clock and data share one synchroniser
	cdlc_sync #(
		.W(2)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({card_clock, card_dat_in}),
		.dout({ck_s, dat_s})
	);

	cdlc_fifo #(
		.HALF(HALF_BYTES)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.wp_rst(s.wprst),
		.rp_rst(s.rprst),
		.push(push),
		.push_data(push_data),
		.pop(pop),
		.pop_data(fifo_out),
		.can_push(can_push),
		.can_pop(can_pop),
		.half_full(hfull),
		.half_empty(hempty)
	);

	assign rise = ck_s && !s.clk_prev;
	assign fall = !ck_s && s.clk_prev;
	assign active = s.st != S_IDLE;
	assign lvl = {hfull[1], hfull[0], hempty[1], hempty[0]};
	assign rx_byte = {s.sh[6:0], dat_s};
	assign acc = psel && penable;
	assign done = acc && s.ready;
	assign rd_snap = s.rdata[IW-1:0];

	// Register access, transfer machine and flags
	always_comb
	begin
		n = s;
		fset = '0;
		push = 1'b0;
		pop = 1'b0;
		push_data = pwdata[7:0];
		n.clk_prev = ck_s;
		n.lvl = lvl;
		// One wait state: data is captured first, effects land at completion
		n.ready = acc && !s.ready;
		n.err = 1'b0;
		if (acc && !s.ready)
		begin
			n.rdata = '0;
			case (paddr)
				A_CTRL0: n.rdata[3:0] = {s.wprst, s.rprst, s.multi, s.fmt};
				A_CTRL1: n.rdata[5:0] = {s.startb, s.dir, s.blen};
				A_CTRL2: n.rdata[3:0] = {s.data_ctrl_reset, s.dly, s.flow};
				A_STATUS:
				begin
					n.rdata[ST_FMT] = s.fmt_ok;
					n.rdata[ST_CRC] = s.crc_ok;
					n.rdata[ST_BUSY] = s.busy;
					n.rdata[ST_H1E] = hempty[0];
					n.rdata[ST_H2E] = hempty[1];
					n.rdata[ST_H1F] = hfull[0];
					n.rdata[ST_H2F] = hfull[1];
					n.rdata[ST_ACT] = active;
					n.rdata[ST_RUN] = s.run;
				end
				A_IRQ: n.rdata[IW-1:0] = s.flags;
				A_MASK: n.rdata[IW-1:0] = s.mask;
				A_DATA: n.rdata[7:0] = can_pop ? fifo_out : 8'h00;
				default: n.err = 1'b1;
			endcase
		end
		if (done && pwrite)
		begin
			case (paddr)
				A_CTRL0:
				begin
					n.fmt = pwdata[C0_FMT];
					n.multi = pwdata[C0_MULTI];
					n.rprst = pwdata[C0_RPRST];
					n.wprst = pwdata[C0_WPRST];
				end
				A_CTRL1:
				begin
					// Reserved length codes are clamped to the longest block
					n.blen = (pwdata[C1_LEN+:4] > BLEN_MAX) ? BLEN_MAX : pwdata[C1_LEN+:4]; // R3
					n.dir = pwdata[C1_DIR];
					n.startb = pwdata[C1_START];
				end
				A_CTRL2:
				begin
					n.flow = pwdata[C2_FLOW];
					n.dly = pwdata[C2_DLY+:2];
					n.data_ctrl_reset = pwdata[C2_DCR];
				end
				A_MASK: n.mask = pwdata[IW-1:0];
				// Writes during reception are dropped to keep the card bytes intact
				A_DATA: push = !(active && !s.xdir); // R19
				default: ;
			endcase
		end
		// Reads during transmission never steal bytes from the sender
		if (done && !pwrite && paddr == A_DATA)
			pop = !(active && s.xdir); // R19
		start_ev = s.startb && !n.startb; // R6
		if (resp_done)
		begin
			n.resp_seen = 1'b1;
			n.resp_good = resp_ok;
		end
		if (cmd_done && active)
			n.stop_seen = 1'b1;
		unique case (s.st)
			S_IDLE:
				if (start_ev)
				begin
					n.xdir = s.dir;
					n.xblk = s.fmt; // R1
					n.xmulti = s.multi; // R2
					n.xlen = 12'h001 << s.blen; // R3
					n.nbytes = '0;
					n.gap = '0;
					n.stop_seen = 1'b0;
					n.fmt_ok = 1'b0;
					n.crc_ok = 1'b0;
					if (!s.dir)
						n.st = S_RWAIT; // R4
					else if (!s.resp_seen)
						n.st = S_WRESP; // R7
					else
					begin
						n.resp_seen = 1'b0;
						n.st = s.resp_good ? S_GAP : S_IDLE; // R7
					end
				end
			S_WRESP:
				if (resp_done)
				begin
					n.resp_seen = 1'b0;
					n.st = resp_ok ? S_GAP : S_IDLE; // R7
				end
			S_GAP:
				if (s.gap != gap_target(s.dly))
				begin
					if (rise)
						n.gap = s.gap + 4'h1; // R9
				end
				else if (dat_s)
					n.st = S_TSTART; // R8
			S_TSTART:
				if (fall)
				begin
					n.dout = 1'b0;
					n.doe_n = 1'b0;
					n.crc = '0;
					n.bits = '0;
					n.nbytes = '0;
					n.st = S_TDATA;
				end
			S_TDATA:
				if (fall && s.bits != '0)
				begin
					n.dout = s.sh[7];
					n.sh = {s.sh[14:0], 1'b0};
					n.bits = s.bits - 4'h1;
					n.crc = crc_step(s.crc, s.sh[7]);
				end
				else if (fall && s.xblk && s.nbytes == s.xlen)
				begin
					n.dout = s.crc[15];
					n.sh = {s.crc[14:0], 1'b0};
					n.bits = CRC_REST;
					n.st = S_TCRC;
				end
				else if (fall && !s.xblk && s.stop_seen)
				begin
					n.dout = 1'b1; // R10
					n.st = S_TEND;
				end
				else if (fall && can_pop)
				begin
					pop = 1'b1;
					n.dout = fifo_out[7];
					n.sh = {8'h00, fifo_out[6:0], 1'b0};
					n.bits = BYTE_REST;
					n.crc = crc_step(s.crc, fifo_out[7]);
					n.nbytes = s.nbytes + 12'h001;
				end
			S_TCRC:
				if (fall && s.bits != '0)
				begin
					n.dout = s.sh[15];
					n.sh = {s.sh[14:0], 1'b0};
					n.bits = s.bits - 4'h1;
				end
				else if (fall)
				begin
					n.dout = 1'b1;
					n.st = S_TEND;
				end
			S_TEND:
				if (fall)
				begin
					n.doe_n = 1'b1;
					n.tok = '0;
					n.sh = '0;
					if (s.xblk)
						n.st = S_TTOK;
					else
					begin
						fset[I_EOF] = 1'b1; // R10
						n.fmt_ok = 1'b1;
						n.st = S_IDLE;
					end
				end
			S_TTOK:
				if (rise && s.tok == '0)
				begin
					if (!dat_s)
						n.tok = 3'h1;
				end
				else if (rise && s.tok != TOK_END)
				begin
					n.sh = {s.sh[14:0], dat_s};
					n.tok = s.tok + 3'h1;
				end
				else if (rise)
				begin
					fset[I_EOF] = 1'b1; // R11
					n.fmt_ok = dat_s;
					n.crc_ok = s.sh[2:0] == TOK_OK;
					n.st = S_TBUSY;
				end
			S_TBUSY:
				if (rise)
				begin
					n.busy = !dat_s; // R12
					if (dat_s)
						n.st = (s.xmulti && !s.stop_seen) ? S_TSTART : S_IDLE; // R8
				end
			S_RWAIT:
				if (rise && !dat_s)
				begin
					n.bits = RX_BITS;
					n.crc = '0;
					n.st = S_RDATA;
				end
				else if (s.stop_seen)
					n.st = S_IDLE;
			S_RDATA:
				if (rise)
				begin
					n.sh = {8'h00, rx_byte};
					n.crc = crc_step(s.crc, dat_s);
					n.bits = s.bits - 4'h1;
					if (s.bits == 4'h1)
					begin
						push = 1'b1;
						push_data = rx_byte;
						n.nbytes = s.nbytes + 12'h001;
						n.bits = RX_BITS;
						if (s.xblk && n.nbytes == s.xlen)
						begin
							n.bits = CRC_REST;
							n.st = S_RCRC;
						end
						else if (!s.xblk && s.stop_seen)
							n.st = S_REND;
					end
				end
			S_RCRC:
				if (rise)
				begin
					n.crc = crc_step(s.crc, dat_s);
					n.bits = s.bits - 4'h1;
					if (s.bits == '0)
						n.st = S_REND;
				end
			S_REND:
				if (rise)
				begin
					fset[I_EOF] = 1'b1; // R13
					n.fmt_ok = dat_s;
					n.crc_ok = s.xblk && s.crc == '0; // R13
					n.nbytes = '0;
					n.st = (s.xblk && s.xmulti && !s.stop_seen) ? S_RWAIT : S_IDLE;
				end
			default: n.st = S_IDLE;
		endcase
		// Controller reset holds the machine idle and frees the line
		if (s.data_ctrl_reset)
		begin
			n.st = S_IDLE; // R14
			n.doe_n = 1'b1;
			n.dout = 1'b1;
			n.busy = 1'b0;
		end
		// Flow control only acts while a transfer is running
		n.run = !(s.flow && active && (s.xdir ? &hempty : &hfull)); // R17 R18 R19
		fset[I_BUSY] = n.busy != s.busy; // R12
		fset[I_EOR] = resp_done;
		fset[I_EOC] = cmd_done;
		fset[I_H1E] = lvl[0] && !s.lvl[0]; // R20
		fset[I_H2E] = lvl[1] && !s.lvl[1];
		fset[I_H1F] = lvl[2] && !s.lvl[2];
		fset[I_H2F] = lvl[3] && !s.lvl[3];
		// Clearing by read uses the captured value, so a new event is never lost
		n.flags = s.flags | fset;
		if (done && !pwrite && paddr == A_IRQ)
			n.flags = (s.flags & ~rd_snap) | fset; // R22
		n.irq = irq_global_en && |(s.flags & ~s.mask); // R21
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= S_IDLE;
			s.mask <= MASK_RST;
			s.dout <= 1'b1;
			s.doe_n <= 1'b1;
			s.run <= 1'b1;
			s.lvl <= 4'h3;
		end
		else
			s <= n;
	end

	assign prdata = s.rdata;
	assign pready = s.ready;
	assign pslverr = s.err;
	assign card_dat_out = s.dout;
	assign card_dat_oe_n = s.doe_n;
	assign card_clock_run = s.run;
	assign irq_req = s.irq;

	irq_raise_a: assert property (@(posedge clk_sys) disable iff (rst) // R21
		(irq_global_en && |(s.flags & ~s.mask)) |=> irq_req)
		else $error("unmasked flag gave no interrupt");
	read_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // R22
		(done && !pwrite && paddr == A_IRQ && fset == '0) |=> (s.flags & $past(rd_snap)) == '0)
		else $error("flag read did not clear");
	tx_dir_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
		(s.st == S_TDATA || s.st == S_TCRC || s.st == S_GAP) |-> s.xdir)
		else $error("transmit state without transmit direction");
	busy_change_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
		(s.busy != $past(s.busy)) |-> s.flags[I_BUSY])
		else $error("busy change not flagged");
	write_gap_a: assert property (@(posedge clk_sys) disable iff (rst) // R9
		(s.st == S_GAP ##1 s.st == S_TSTART) |-> s.gap == gap_target(s.dly))
		else $error("write gap too short");
	tx_flow_a: assert property (@(posedge clk_sys) disable iff (rst) // R17
		(active && s.xdir && s.flow && &hempty) |=> !card_clock_run)
		else $error("clock not stopped with both halves empty");
	rx_flow_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
		(active && !s.xdir && s.flow && &hfull) |=> !card_clock_run)
		else $error("clock not stopped with both halves full");
	stream_crc_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
		(s.st == S_REND && rise && !s.xblk) |=> (!s.crc_ok && s.flags[I_EOF]))
		else $error("stream end reported a CRC status");
	ctrl_reset_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
		s.data_ctrl_reset |=> (s.st == S_IDLE && card_dat_oe_n))
		else $error("controller reset left machine running");
	token_eof_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
		(s.st == S_TTOK && rise && s.tok == TOK_END) |=> (s.flags[I_EOF] && s.st == S_TBUSY))
		else $error("status token did not end the frame");
endmodule
`default_nettype wire

// File: pkg/cdlc_pkg.sv
// Constants shared by the card data line controller files
package cdlc_pkg;
	// APB address and data widths
	localparam int AW = 8;
	localparam int DW = 32;
	// Register byte offsets
	localparam logic [AW-1:0] A_CTRL0 = 8'h00;
	localparam logic [AW-1:0] A_CTRL1 = 8'h04;
	localparam logic [AW-1:0] A_CTRL2 = 8'h08;
	localparam logic [AW-1:0] A_STATUS = 8'h0c;
	localparam logic [AW-1:0] A_IRQ = 8'h10;
	localparam logic [AW-1:0] A_MASK = 8'h14;
	localparam logic [AW-1:0] A_DATA = 8'h18;
	// Control register 0 fields
	localparam int C0_FMT = 0;
	localparam int C0_MULTI = 1;
	localparam int C0_RPRST = 2;
	localparam int C0_WPRST = 3;
	// Control register 1 fields
	localparam int C1_LEN = 0;
	localparam int C1_DIR = 4;
	localparam int C1_START = 5;
	// Control register 2 fields
	localparam int C2_FLOW = 0;
	localparam int C2_DLY = 1;
	localparam int C2_DCR = 3;
	// Status register fields
	localparam int ST_FMT = 0;
	localparam int ST_CRC = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_H1E = 3;
	localparam int ST_H2E = 4;
	localparam int ST_H1F = 5;
	localparam int ST_H2F = 6;
	localparam int ST_ACT = 7;
	localparam int ST_RUN = 8;
	// Interrupt flag and mask positions
	localparam int IW = 8;
	localparam int I_H1E = 0;
	localparam int I_H2E = 1;
	localparam int I_H1F = 2;
	localparam int I_H2F = 3;
	localparam int I_EOF = 4;
	localparam int I_EOC = 5;
	localparam int I_EOR = 6;
	localparam int I_BUSY = 7;
	// Reset values
	localparam logic [IW-1:0] MASK_RST = 8'hff;
	// Block length limit and write gap, in card clock periods
	localparam logic [3:0] BLEN_MAX = 4'hb;
	localparam logic [3:0] GAP_BASE = 4'h3;
	localparam int GAP_STEP = 2;
	// Line framing
	localparam int HALF_BYTES = 8;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [2:0] TOK_OK = 3'h2;
	localparam logic [2:0] TOK_END = 3'h4;
	localparam logic [3:0] BYTE_REST = 4'h7;
	localparam logic [3:0] CRC_REST = 4'hf;
	localparam logic [3:0] RX_BITS = 4'h8;
endpackage

// File: verilog/cdlc_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for pins from the card side
module cdlc_sync #(
	parameter int W = 2 // Number of bits
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [W-1:0] din, // Asynchronous inputs
	output logic [W-1:0] dout // Synchronised outputs
);
	import cdlc_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} cdlc_sync_s;

	cdlc_sync_s s;
	cdlc_sync_s n;

	if (W < 1)
	begin : g_chk
		$error("cdlc_sync needs at least one bit");
	end

	// First stage is read only by the second
	always_comb
	begin
		n.meta = din;
		n.stab = s.meta;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	assign dout = s.stab;
endmodule
`default_nettype wire

// File: verilog/cdlc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// Data buffer built from two halves, filled and drained in turn
module cdlc_fifo #(
	parameter int HALF = cdlc_pkg::HALF_BYTES // Bytes per half
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic wp_rst, // Hold write pointer at zero
	input wire logic rp_rst, // Hold read pointer at zero
	input wire logic push, // Write a byte
	input wire logic [7:0] push_data, // Byte to write
	input wire logic pop, // Read a byte
	output logic [7:0] pop_data, // Byte at the read pointer
	output logic can_push, // Current write half has room
	output logic can_pop, // Current read half holds data
	output logic [1:0] half_full, // Per-half full levels
	output logic [1:0] half_empty // Per-half empty levels
);
	import cdlc_pkg::*;
	localparam int PW = $clog2(2 * HALF);
	localparam int CW = $clog2(HALF) + 1;

	typedef struct packed {
		logic [2*HALF-1:0][7:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [1:0][CW-1:0] cnt;
	} cdlc_fifo_s;

	cdlc_fifo_s s;
	cdlc_fifo_s n;
	logic wh;
	logic rh;
	logic push_ok;
	logic pop_ok;

	if (HALF < 2 || (HALF & (HALF - 1)) != 0)
	begin : g_chk
		$error("cdlc_fifo half size must be a power of two");
	end

	// The top pointer bit names the half, so halves alternate in byte order
	assign wh = s.wp[PW-1]; // R25
	assign rh = s.rp[PW-1];
	assign can_push = s.cnt[wh] != CW'(HALF);
	assign can_pop = s.cnt[rh] != '0;
	assign push_ok = push && can_push;
	assign pop_ok = pop && can_pop;
	assign pop_data = s.mem[s.rp];

	// Pointer and per-half count update
	always_comb
	begin
		n = s;
		if (push_ok)
		begin
			n.mem[s.wp] = push_data;
			n.wp = s.wp + 1'b1;
		end
		if (pop_ok)
			n.rp = s.rp + 1'b1;
		for (int i = 0; i < 2; i++)
			n.cnt[i] = s.cnt[i] + CW'(push_ok && wh == 1'(i)) - CW'(pop_ok && rh == 1'(i)); // R23
		// A pointer reset abandons whatever was in flight
		if (wp_rst)
		begin
			n.wp = '0; // R24
			n.cnt = '0;
		end
		if (rp_rst)
		begin
			n.rp = '0; // R24
			n.cnt = '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	// Level flags for both halves
	for (genvar g = 0; g < 2; g++)
	begin : g_lvl
		assign half_full[g] = s.cnt[g] == CW'(HALF); // R23
		assign half_empty[g] = s.cnt[g] == '0;
	end
endmodule
`default_nettype wire

// File: verif/cdlc_card.sv
`timescale 1ns/100ps
`default_nettype none
// Card on the far side: clocks only inside frames, sends read frames, answers writes
module cdlc_card (
	input wire logic run, // Low stops the clock
	input wire logic dat_out, // Host data bit
	input wire logic oe_n, // Host drives when low
	output logic card_clock, // Link clock
	output logic line // Resolved data line
);
	logic en;
	logic drv;
	logic val;
	logic endb;
	logic [7:0] got[$];
	// Pull-up wins when nobody drives, so a released line never shows stale data
	assign line = !oe_n ? dat_out : (drv ? val : 1'b1);
	// Clock off-phase to the system clock, still outside frames
	initial
	begin
		en = 0;
		drv = 0;
		val = 1;
		card_clock = 0;
		#37;
		forever
		begin
			#400;
			if (en && run)
				card_clock = ~card_clock;
		end
	end
	// One CRC16 step, checked independently of the host
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? cdlc_pkg::CRC_POLY : 16'h0000);
	endfunction
	// Card changes its line just after a falling edge
	task automatic put(input logic b);
		@(negedge card_clock);
		drv = 1;
		val = b;
	endtask
	task automatic spin(input int n);
		en = 1;
		repeat (n) @(negedge card_clock);
		en = 0;
	endtask
	// Release, then keep clocking a while before stopping
	task automatic done;
		@(negedge card_clock);
		drv = 0;
		spin(8);
	endtask
	// Read frame: start bit, bytes MSB first, CRC16, end bit
	task automatic send(input logic [7:0] d[$]);
		logic [15:0] c;
		c = 16'h0000;
		en = 1;
		put(1'b1);
		put(1'b0);
		foreach (d[i])
			for (int k = 7; k >= 0; k--)
			begin
				put(d[i][k]);
				c = crc_step(c, d[i][k]);
			end
		for (int k = 15; k >= 0; k--)
			put(c[k]);
		put(1'b1);
		done();
	endtask
	// Write frame: capture n bytes, then status token and a short busy
	task automatic take(input int n, input logic [2:0] tok);
		logic [7:0] b;
		int t;
		got.delete();
		en = 1;
		t = 0;
		do
		begin
			@(posedge card_clock);
			t++;
		end
		while (line !== 1'b0 && t < 400);
		for (int i = 0; i < n; i++)
		begin
			for (int k = 7; k >= 0; k--)
			begin
				@(posedge card_clock);
				b[k] = line;
			end
			got.push_back(b);
		end
		repeat (17) @(posedge card_clock);
		endb = line;
		put(1'b1);
		put(1'b0);
		for (int k = 2; k >= 0; k--)
			put(tok[k]);
		put(1'b1);
		repeat (4) put(1'b0);
		done();
	endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cdlc_pkg::*;
	logic clk_sys, rst, psel, penable, pwrite, resp_done, resp_ok, cmd_done, irq_global_en;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata, r;
	logic pready, pslverr, e, card_clock, line, dat_out, oe_n, run, irq_req;
	int num_errors, n_checks, cyc, hits;
	logic [7:0] q[$];
	cdlc_top uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.card_clock(card_clock), .card_dat_in(line), .card_dat_out(dat_out),
		.card_dat_oe_n(oe_n), .card_clock_run(run), .resp_done(resp_done), .resp_ok(resp_ok),
		.cmd_done(cmd_done), .irq_global_en(irq_global_en), .irq_req(irq_req));
	cdlc_card card (.run(run), .dat_out(dat_out), .oe_n(oe_n), .card_clock(card_clock),
		.line(line));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Request held until pready is seen; data taken at that same edge
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// One-cycle strobe on the response or command line, driven here by name
	task automatic pulse(input logic rsp);
		@(posedge clk_sys);
		if (rsp)
			resp_done <= 1;
		else
			cmd_done <= 1;
		@(posedge clk_sys);
		resp_done <= 0;
		cmd_done <= 0;
	endtask
	// Pointer reset pulse aborts leftovers, then the format bits stay
	task automatic cfg(input logic [DW-1:0] c0, input logic [DW-1:0] c1);
		apb(1, A_CTRL0, c0 | 32'h1 << C0_RPRST | 32'h1 << C0_WPRST);
		apb(1, A_CTRL0, c0);
		apb(1, A_CTRL1, c1);
	endtask
	task automatic go(input logic [DW-1:0] c1);
		apb(1, A_CTRL1, c1 | 32'h1 << C1_START);
		apb(1, A_CTRL1, c1);
	endtask
	task automatic t_reset;
		apb(0, A_MASK, 0);
		chk(r, 32'hff);
		apb(0, A_STATUS, 0);
		chk(r, 32'h118);
		apb(0, 8'h40, 0);
		chk(r, 0);
		chk(e, 1);
		pulse(0);
		apb(0, A_IRQ, 0);
		chk(r, 32'h1 << I_EOC);
		apb(0, A_IRQ, 0);
		chk(r, 0);
	endtask
	// Bad response status: nothing may reach the line
	task automatic t_badresp;
		cfg(32'h1, 32'h10);
		apb(1, A_DATA, 32'h5a);
		go(32'h10);
		resp_ok <= 0;
		pulse(1);
		hits = 0;
		fork
			card.spin(30);
			repeat (240)
			begin
				@(posedge clk_sys);
				if (oe_n !== 1'b1)
					hits++;
			end
		join
		chk(hits, 0);
		apb(0, A_STATUS, 0);
		chk(r[ST_ACT], 0);
	endtask
	// Write start with an empty buffer under flow control, then a controller reset
	task automatic t_abort;
		cfg(32'h1, 32'h10);
		apb(1, A_CTRL2, 32'h1);
		go(32'h10);
		apb(0, A_STATUS, 0);
		chk(r[ST_RUN:ST_ACT], 2'h1);
		chk(run, 0);
		apb(1, A_DATA, 32'h33);
		repeat (2) @(posedge clk_sys);
		chk(run, 1);
		apb(1, A_CTRL2, 32'h1 << C2_DCR);
		apb(1, A_CTRL2, 0);
		apb(0, A_STATUS, 0);
		chk(r[ST_ACT], 0);
	endtask
	// Block write of 4 bytes, token decides the CRC status
	task automatic t_write(input logic [2:0] tok, input logic [1:0] dly);
		logic [31:0] m;
		m = 32'h1 << I_EOF | 32'h1 << I_BUSY | 32'h1 << I_EOR | 32'h1 << I_H1E;
		q = {8'h3c, 8'ha5, 8'h01, 8'hf0};
		cfg(32'h1, 32'h12);
		apb(1, A_CTRL2, {29'h0, dly, 1'b0});
		foreach (q[i])
			apb(1, A_DATA, {24'h0, q[i]});
		apb(0, A_IRQ, 0);
		go(32'h12);
		resp_ok <= 1;
		fork
			card.take(4, tok);
			pulse(1);
		join
		foreach (q[i])
			chk(card.got[i], q[i]);
		chk(card.endb, 1);
		apb(0, A_STATUS, 0);
		chk(r[2:0], {1'b0, tok == TOK_OK, 1'b1});
		apb(0, A_IRQ, 0);
		chk(r & m, m);
	endtask
	// Block read of 8 bytes with the end of frame unmasked
	task automatic t_read;
		q = {8'h81, 8'h7e, 8'h00, 8'hff, 8'h12, 8'h34, 8'hc6, 8'h09};
		cfg(32'h1, 32'h3);
		apb(1, A_MASK, ~(32'h1 << I_EOF));
		irq_global_en <= 1;
		go(32'h3);
		card.send(q);
		repeat (4) @(posedge clk_sys);
		chk(irq_req, 1);
		apb(0, A_STATUS, 0);
		chk({r[ST_H1F], r[1:0]}, 3'h7);
		foreach (q[i])
		begin
			apb(0, A_DATA, 0);
			chk(r, q[i]);
		end
		apb(0, A_IRQ, 0);
		chk({r[I_EOF], r[I_H1F]}, 2'h3);
		repeat (2) @(posedge clk_sys);
		chk(irq_req, 0);
	endtask
	initial
	begin
		clk_sys = 0;
		forever
			#50 clk_sys = ~clk_sys;
	end
	// Hang guard
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			close_out();
		end
	end
	initial
	begin
		{rst, psel, penable, pwrite, resp_done, resp_ok, cmd_done, irq_global_en} = 8'h80;
		paddr = 0;
		pwdata = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		t_reset();
		t_badresp();
		t_abort();
		t_write(TOK_OK, 2'h0);
		t_write(3'h5, 2'h3);
		t_read();
		close_out();
	end
endmodule
`default_nettype wire
